// ---- core/i2c_client_top.sv ----
// i2c_client_top: two-wire bus register client with strap-set address
// assumes: bus pins are asynchronous and are oversampled by the 200 MHz clock;
// open-drain data line, pulled up outside, only ever driven low
`timescale 1ns/1ps
`default_nettype none
module i2c_client_top #(
    parameter int REG_DEPTH = 32,
    parameter int NVM_PROG_CYCLES = 16
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    input wire logic interface_select_pin_in,
    input wire logic [1:0] chip_select_address_pin_in,
    input wire logic [4:0] nvm_addr_msb_in,
    input wire logic [i2c_client_pkg::NUM_LOOPS-1:0] loop_lock_lost_flag_in,
    output i2c_client_pkg::loop_ctrl_t loop_ctrl_out,
    output logic [i2c_client_pkg::NUM_LOOPS-1:0] interrupt_status_flags_out,
    output logic nvm_write_out,
    output logic [4:0] nvm_data_out,
    output logic [6:0] client_address_out
);
    import i2c_client_pkg::*;

    typedef struct packed {
        phase_t phase;
        logic scl_d;
        logic sda_d;
        logic [3:0] bit_cnt;
        logic [7:0] shreg;
        logic rw;
        logic [1:0] byte_idx;
        logic [15:0] ptr;
        logic sda_oe;
        logic [1:0] settle;
        logic ready;
        logic enabled;
        logic [6:0] own_addr;
        reg_wr_t wr;
    } client_state_t;

    client_state_t s_reg, s_next;
    pins_t pins_raw, pins;
    logic scl_rise, scl_fall, start_cond, stop_cond, addr_match;
    logic [7:0] rd_data;

    assign pins_raw = '{
        lock_lost: loop_lock_lost_flag_in,
        nvm_msb: nvm_addr_msb_in,
        addr_pin: chip_select_address_pin_in,
        iface: interface_select_pin_in,
        sda: sda_in,
        scl: scl_in
    };

    pin_sync #(
        .W($bits(pins_t))
    ) u_sync (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .d_in(pins_raw),
        .q_out(pins)
    );

    reg_space #(
        .DEPTH(REG_DEPTH),
        .NVM_PROG_CYCLES(NVM_PROG_CYCLES)
    ) u_regs (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .wr_in(s_reg.wr),
        .rd_addr_in(s_reg.ptr),
        .rd_data_out(rd_data),
        .lock_lost_in(pins.lock_lost),
        .ctrl_out(loop_ctrl_out),
        .flags_out(interrupt_status_flags_out),
        .nvm_write_out(nvm_write_out),
        .nvm_data_out(nvm_data_out)
    );

    // no bit-rate timer: edges are found by oversampling, so any slower rate also works
    assign scl_rise = pins.scl && !s_reg.scl_d;
    assign scl_fall = !pins.scl && s_reg.scl_d;
    assign start_cond = s_reg.sda_d && !pins.sda && pins.scl && s_reg.scl_d;
    assign stop_cond = !s_reg.sda_d && pins.sda && pins.scl && s_reg.scl_d;
    assign addr_match = s_reg.shreg[7:1] == s_reg.own_addr;

    always_comb begin
        s_next = s_reg;
        s_next.wr.en = 1'b0;
        s_next.scl_d = pins.scl;
        s_next.sda_d = pins.sda;
        if (!s_reg.ready) begin
            // straps are taken once, after the synchronisers have filled
            if (s_reg.settle == STRAP_SETTLE) begin
                s_next.ready = 1'b1;
                s_next.enabled = !pins.iface;
                s_next.own_addr[6:2] = pins.nvm_msb;
                s_next.own_addr[1:0] = strap_lsbs(pins.addr_pin);
            end else begin
                s_next.settle = s_reg.settle + 2'h1;
            end
        end else if (!s_reg.enabled) begin
            s_next.phase = PH_IDLE;
            s_next.sda_oe = 1'b0;
        end else if (start_cond) begin
            // a repeated start keeps the pointer so a read follows its write
            s_next.phase = PH_ADDR;
            s_next.bit_cnt = '0;
            s_next.sda_oe = 1'b0;
        end else if (stop_cond) begin
            s_next.phase = PH_IDLE;
            s_next.sda_oe = 1'b0;
        end else begin
            unique case (s_reg.phase)
                PH_IDLE: begin
                    s_next.sda_oe = 1'b0;
                end
                PH_ADDR, PH_RX: begin
                    if (scl_rise) begin
                        s_next.shreg = {s_reg.shreg[6:0], pins.sda};
                        s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
                    end else if (scl_fall && s_reg.bit_cnt == BITS_PER_BYTE) begin
                        s_next.bit_cnt = '0;
                        if (s_reg.phase == PH_ADDR) begin
                            if (addr_match) begin
                                s_next.sda_oe = 1'b1;
                                s_next.phase = PH_ACK;
                                s_next.rw = s_reg.shreg[0];
                                if (!s_reg.shreg[0]) begin
                                    s_next.byte_idx = BYTE_PTR_HI;
                                end
                            end else begin
                                s_next.phase = PH_IDLE;
                            end
                        end else begin
                            s_next.sda_oe = 1'b1;
                            s_next.phase = PH_ACK;
                            if (s_reg.byte_idx != BYTE_DATA) begin
                                s_next.byte_idx = s_reg.byte_idx + 2'h1;
                            end
                            unique case (s_reg.byte_idx)
                                BYTE_PTR_HI: s_next.ptr[15:8] = s_reg.shreg;
                                BYTE_PTR_LO: s_next.ptr[7:0] = s_reg.shreg;
                                default: begin
                                    s_next.wr.en = 1'b1;
                                    s_next.wr.addr = s_reg.ptr;
                                    s_next.wr.data = s_reg.shreg;
                                    s_next.ptr = s_reg.ptr + 16'h0001;
                                end
                            endcase
                        end
                    end
                end
                PH_ACK: begin
                    if (scl_fall) begin
                        if (s_reg.rw) begin
                            s_next.shreg = rd_data;
                            s_next.sda_oe = !rd_data[7];
                            s_next.phase = PH_TX;
                        end else begin
                            s_next.sda_oe = 1'b0;
                            s_next.phase = PH_RX;
                        end
                    end
                end
                PH_TX: begin
                    if (scl_rise) begin
                        s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (s_reg.bit_cnt == BITS_PER_BYTE) begin
                            s_next.sda_oe = 1'b0;
                            s_next.bit_cnt = '0;
                            s_next.phase = PH_MACK;
                        end else begin
                            s_next.shreg = {s_reg.shreg[6:0], 1'b0};
                            s_next.sda_oe = !s_reg.shreg[6];
                        end
                    end
                end
                PH_MACK: begin
                    if (scl_rise) begin
                        if (pins.sda) begin
                            s_next.phase = PH_IDLE;
                        end else begin
                            s_next.ptr = s_reg.ptr + 16'h0001;
                        end
                    end else if (scl_fall) begin
                        s_next.shreg = rd_data;
                        s_next.sda_oe = !rd_data[7];
                        s_next.phase = PH_TX;
                    end
                end
                default: begin
                    s_next.phase = PH_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // the line is only ever pulled low; the pull-up makes the high level
    assign sda_out = 1'b0;
    assign sda_oe_out = s_reg.sda_oe;
    assign client_address_out = s_reg.own_addr;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    logic was_ready;
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            was_ready <= 1'b0;
        end else begin
            was_ready <= s_reg.ready;
        end
    end

    property p_disabled;
        s_reg.ready && !s_reg.enabled |-> !sda_oe_out;
    endproperty
    a_disabled: assert property (p_disabled) else $error("client drove bus while deselected");

    property p_msb_load;
        s_reg.ready && !was_ready |-> client_address_out[6:2] == $past(pins.nvm_msb);
    endproperty
    a_msb_load: assert property (p_msb_load) else $error("upper address bits not loaded");

    property p_strap;
        s_reg.ready && !was_ready |-> client_address_out[1:0] == strap_lsbs($past(pins.addr_pin));
    endproperty
    a_strap: assert property (p_strap) else $error("strap bits wrong");

    property p_default_addr;
        s_reg.ready && !was_ready && $past(pins.nvm_msb) == DEFAULT_ADDR_MSB
            && $past(pins.addr_pin) == PIN_LOW |-> client_address_out == DEFAULT_ADDR_PIN_LOW;
    endproperty
    a_default_addr: assert property (p_default_addr) else $error("default address wrong");

    property p_start;
        s_reg.ready && s_reg.enabled && start_cond |=> s_reg.phase == PH_ADDR && !sda_oe_out;
    endproperty
    a_start: assert property (p_start) else $error("start not taken");

    sequence s_addr_done;
        s_reg.phase == PH_ADDR && !start_cond && !stop_cond && scl_fall
            && s_reg.bit_cnt == BITS_PER_BYTE;
    endsequence
    property p_addr_ack;
        s_addr_done ##0 addr_match |=> sda_oe_out && s_reg.phase == PH_ACK;
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("own address not acknowledged");

    property p_foreign;
        s_addr_done ##0 !addr_match |=> !sda_oe_out && s_reg.phase == PH_IDLE;
    endproperty
    a_foreign: assert property (p_foreign) else $error("foreign address acknowledged");

    sequence s_rx_done;
        s_reg.phase == PH_RX && !start_cond && !stop_cond && scl_fall
            && s_reg.bit_cnt == BITS_PER_BYTE;
    endsequence
    property p_ptr_hi;
        s_rx_done ##0 s_reg.byte_idx == BYTE_PTR_HI |=> s_reg.ptr[15:8] == $past(s_reg.shreg);
    endproperty
    a_ptr_hi: assert property (p_ptr_hi) else $error("pointer high byte not loaded");

    property p_incr;
        s_rx_done ##0 s_reg.byte_idx == BYTE_DATA
            |=> s_reg.wr.en && s_reg.wr.addr == $past(s_reg.ptr)
            && s_reg.ptr == $past(s_reg.ptr) + 16'h0001;
    endproperty
    a_incr: assert property (p_incr) else $error("block write pointer not advanced");

    property p_tx_release;
        s_reg.phase == PH_TX && !start_cond && !stop_cond && scl_fall
            && s_reg.bit_cnt == BITS_PER_BYTE |=> !sda_oe_out && s_reg.phase == PH_MACK;
    endproperty
    a_tx_release: assert property (p_tx_release) else $error("line held after read byte");
endmodule // i2c_client_top
`default_nettype wire

// ---- common/i2c_client_pkg.sv ----
// i2c_client_pkg: constants, register offsets and carrier types of the two-wire client
// assumes: one 200 MHz clock domain; all pins are synchronised before use
package i2c_client_pkg;
    localparam int NUM_LOOPS = 3;

    // register offsets
    localparam logic [15:0] REG_LOCK_STATUS = 16'h000C;
    localparam logic [15:0] REG_INT_FLAGS = 16'h000D;
    localparam logic [15:0] REG_SYNC_TRIG = 16'h0015;
    localparam logic [15:0] REG_SOFT_RESET = 16'h0017;
    localparam logic [15:0] REG_SYNC_EN = 16'h0019;
    localparam logic [15:0] REG_NVM_CTRL = 16'h00AB;
    localparam logic [15:0] REG_NVM_STAGE = 16'h00B0;

    // field positions
    localparam int SYNC_TRIG_BIT = 6;
    localparam int GLOBAL_RST_BIT = 6;
    localparam int DIGITAL_RST_LSB = 3;
    localparam int ANALOG_RST_LSB = 0;
    localparam int SYNC_EN_BIT = 0;
    localparam int NVM_PROG_BIT = 0;
    localparam int NVM_BUSY_BIT = 2;

    localparam logic [4:0] DEFAULT_ADDR_MSB = 5'h19;
    localparam logic [6:0] DEFAULT_ADDR_PIN_LOW = 7'h64;
    localparam logic [1:0] STRAP_SETTLE = 2'h3;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [1:0] BYTE_PTR_HI = 2'h0;
    localparam logic [1:0] BYTE_PTR_LO = 2'h1;
    localparam logic [1:0] BYTE_DATA = 2'h2;

    // strap pin level codes
    localparam logic [1:0] PIN_LOW = 2'h0;
    localparam logic [1:0] PIN_HIGH = 2'h1;
    localparam logic [1:0] PIN_MID = 2'h2;

    typedef enum logic [2:0] {PH_IDLE, PH_ADDR, PH_RX, PH_ACK, PH_TX, PH_MACK} phase_t;

    typedef struct packed {
        logic [NUM_LOOPS-1:0] lock_lost;
        logic [4:0] nvm_msb;
        logic [1:0] addr_pin;
        logic iface;
        logic sda;
        logic scl;
    } pins_t;

    typedef struct packed {
        logic en;
        logic [15:0] addr;
        logic [7:0] data;
    } reg_wr_t;

    typedef struct packed {
        logic global_soft_reset;
        logic [NUM_LOOPS-1:0] digital_loop_soft_reset;
        logic [NUM_LOOPS-1:0] analog_loop_soft_reset;
        logic sync_enable;
        logic software_sync_trigger;
    } loop_ctrl_t;

    // an unused fourth level code falls back to the low address
    function automatic logic [1:0] strap_lsbs(input logic [1:0] level);
        logic [1:0] r;
        r = 2'h0;
        if (level == PIN_HIGH) begin
            r = 2'h1;
        end else if (level == PIN_MID) begin
            r = 2'h2;
        end
        return r;
    endfunction
endpackage

// ---- core/pin_sync.sv ----
// pin_sync: two-flop synchroniser for a vector of asynchronous pins
// assumes: each bit is a level; bits are not related to one another
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int W = 8
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] q;
    } sync_state_t;

    sync_state_t s_reg, s_next;

    always_comb begin
        s_next.meta = d_in;
        s_next.q = s_reg.meta;
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign q_out = s_reg.q;
endmodule // pin_sync
`default_nettype wire

// ---- core/reg_space.sv ----
// reg_space: register storage, self-clearing loop resets, sticky flags, staging transfer
// assumes: one write request per cycle from the bus client; lock inputs are synchronised
`timescale 1ns/1ps
`default_nettype none
module reg_space #(
    parameter int DEPTH = 32,
    parameter int NVM_PROG_CYCLES = 16
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire i2c_client_pkg::reg_wr_t wr_in,
    input wire logic [15:0] rd_addr_in,
    output logic [7:0] rd_data_out,
    input wire logic [i2c_client_pkg::NUM_LOOPS-1:0] lock_lost_in,
    output i2c_client_pkg::loop_ctrl_t ctrl_out,
    output logic [i2c_client_pkg::NUM_LOOPS-1:0] flags_out,
    output logic nvm_write_out,
    output logic [4:0] nvm_data_out
);
    import i2c_client_pkg::*;

    typedef struct packed {
        logic [DEPTH-1:0][7:0] mem;
        loop_ctrl_t ctrl;
        logic [NUM_LOOPS-1:0] flags;
        logic [4:0] stage;
        logic busy;
        logic [15:0] cnt;
        logic nvm_write;
    } regs_state_t;

    regs_state_t s_reg, s_next;
    logic clear_hit;

    assign clear_hit = wr_in.en && (wr_in.addr == REG_INT_FLAGS);

    always_comb begin
        s_next = s_reg;
        s_next.nvm_write = 1'b0;
        s_next.ctrl.digital_loop_soft_reset = '0;
        s_next.ctrl.analog_loop_soft_reset = '0;
        s_next.flags = s_reg.flags | lock_lost_in;
        if (s_reg.busy) begin
            s_next.cnt = s_reg.cnt + 16'h0001;
            if (s_reg.cnt == 16'(NVM_PROG_CYCLES - 1)) begin
                s_next.busy = 1'b0;
                s_next.nvm_write = 1'b1;
            end
        end
        if (wr_in.en) begin
            case (wr_in.addr)
                REG_SYNC_TRIG: s_next.ctrl.software_sync_trigger = wr_in.data[SYNC_TRIG_BIT];
                REG_SYNC_EN: s_next.ctrl.sync_enable = wr_in.data[SYNC_EN_BIT];
                REG_SOFT_RESET: begin
                    s_next.ctrl.global_soft_reset = wr_in.data[GLOBAL_RST_BIT];
                    s_next.ctrl.digital_loop_soft_reset = wr_in.data[DIGITAL_RST_LSB +: NUM_LOOPS];
                    s_next.ctrl.analog_loop_soft_reset = wr_in.data[ANALOG_RST_LSB +: NUM_LOOPS];
                end
                // set wins over a write-one clear in the same cycle
                REG_INT_FLAGS: s_next.flags = (s_reg.flags & ~wr_in.data[NUM_LOOPS-1:0])
                    | lock_lost_in;
                REG_NVM_STAGE: s_next.stage = wr_in.data[4:0];
                REG_NVM_CTRL: begin
                    if (wr_in.data[NVM_PROG_BIT] && !s_reg.busy) begin
                        s_next.busy = 1'b1;
                        s_next.cnt = '0;
                    end
                end
                default: begin
                    if (wr_in.addr < 16'(DEPTH)) begin
                        s_next.mem[wr_in.addr[$clog2(DEPTH)-1:0]] = wr_in.data;
                    end
                end
            endcase
        end
    end

    always_comb begin
        rd_data_out = 8'h00;
        case (rd_addr_in)
            REG_LOCK_STATUS: rd_data_out[NUM_LOOPS-1:0] = lock_lost_in;
            REG_INT_FLAGS: rd_data_out[NUM_LOOPS-1:0] = s_reg.flags;
            REG_SYNC_TRIG: rd_data_out[SYNC_TRIG_BIT] = s_reg.ctrl.software_sync_trigger;
            REG_SYNC_EN: rd_data_out[SYNC_EN_BIT] = s_reg.ctrl.sync_enable;
            REG_SOFT_RESET: rd_data_out[GLOBAL_RST_BIT] = s_reg.ctrl.global_soft_reset;
            REG_NVM_STAGE: rd_data_out[4:0] = s_reg.stage;
            REG_NVM_CTRL: rd_data_out[NVM_BUSY_BIT] = s_reg.busy;
            default: begin
                if (rd_addr_in < 16'(DEPTH)) begin
                    rd_data_out = s_reg.mem[rd_addr_in[$clog2(DEPTH)-1:0]];
                end
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign ctrl_out = s_reg.ctrl;
    assign flags_out = s_reg.flags;
    assign nvm_write_out = s_reg.nvm_write;
    assign nvm_data_out = s_reg.stage;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    sequence s_loop_reset_write;
        wr_in.en && wr_in.addr == REG_SOFT_RESET && wr_in.data[ANALOG_RST_LSB +: NUM_LOOPS] != '0;
    endsequence
    property p_autoclear;
        s_loop_reset_write ##1 !(wr_in.en && wr_in.addr == REG_SOFT_RESET)
            |=> ctrl_out.analog_loop_soft_reset == '0;
    endproperty
    a_autoclear: assert property (p_autoclear) else $error("loop reset did not clear");

    // every flag, not just one bit: the bench only ever raises the middle loop
    property p_sticky;
        !clear_hit |=> (flags_out & $past(flags_out)) == $past(flags_out);
    endproperty
    a_sticky: assert property (p_sticky) else $error("sticky flag dropped");

    property p_nvm_done;
        $rose(s_reg.busy) |-> ##[1:1000] nvm_write_out;
    endproperty
    a_nvm_done: assert property (p_nvm_done) else $error("staging transfer never ended");
endmodule // reg_space
`default_nettype wire

// ---- verif/host_model.sv ----
// host_model: bit-level two-wire bus controller standing in for the system host
// assumes: the bench resolves the open-drain data wire, pulled up; the clock line is driven high and low by the host
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic clk_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_low_out
);
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end
    // one step is a quarter of the 160 ns bus period
    task automatic put(input logic s, input logic d);
        scl_out <= s;
        sda_low_out <= d;
        repeat (8) @(posedge clk_in);
    endtask
    // also serves as repeated start: data is already released here
    task automatic start;
        put(1'b1, 1'b0);
        put(1'b1, 1'b1);
        put(1'b0, 1'b1);
    endtask
    task automatic stop;
        put(1'b0, 1'b1);
        put(1'b1, 1'b1);
        put(1'b1, 1'b0);
    endtask
    // data only moves while the clock line is low
    task automatic bitw(input logic b);
        put(1'b0, !b);
        put(1'b1, !b);
        put(1'b1, !b);
        put(1'b0, !b);
    endtask
    task automatic bitr(output logic r);
        put(1'b0, 1'b0);
        put(1'b1, 1'b0);
        r = sda_in;
        put(1'b1, 1'b0);
        put(1'b0, 1'b0);
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) bitw(d[i]);
        bitr(a);
        ack = !a;
    endtask
    // last byte of a read is refused so the client lets go of the line
    task automatic rbyte(output logic [7:0] d, input logic last);
        for (int i = 7; i >= 0; i--) bitr(d[i]);
        bitw(last);
    endtask
endmodule // host_model
`default_nettype wire

// ---- verif/tb_top.sv ----
// tb_top: self-checking bench of the two-wire register client
// assumes: host_model drives the bus; reduced store time keeps the run short
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import i2c_client_pkg::*;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic sel = 1'b0;
    logic [1:0] pin = 2'h0;
    logic [4:0] msb = 5'h19;
    logic [2:0] lost = 3'h0;
    logic scl, host_low, sda_out, sda_oe_out, nvm_write_out;
    wire logic sda_w;
    loop_ctrl_t ctrl;
    logic [2:0] flags;
    logic [4:0] nvm_data;
    logic [6:0] caddr;
    logic [5:0] seen = 6'h00;
    logic [5:0] stored = 6'h00;
    logic [6:0] dev = 7'h66;
    int n_fail = 0;
    int num_checks = 0;
    // strap code beside the address it must give; mid level last so it stays
    logic [8:0] rows [4] = '{9'h064, 9'h0E5, 9'h1E4, 9'h166};
    always #2.5 clk_in = ~clk_in;
    assign sda_w = !host_low && (sda_oe_out ? sda_out : 1'b1);
    always @(posedge clk_in) begin
        seen <= seen | (reset_in ? 6'h00 : {ctrl.digital_loop_soft_reset,
            ctrl.analog_loop_soft_reset});
        if (nvm_write_out === 1'b1) stored <= {1'b1, nvm_data};
    end
    host_model host (.clk_in(clk_in), .sda_in(sda_w), .scl_out(scl), .sda_low_out(host_low));
    i2c_client_top #(.NVM_PROG_CYCLES(4)) uut (.clk_in(clk_in), .reset_in(reset_in),
        .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
        .interface_select_pin_in(sel), .chip_select_address_pin_in(pin),
        .nvm_addr_msb_in(msb), .loop_lock_lost_flag_in(lost), .loop_ctrl_out(ctrl),
        .interrupt_status_flags_out(flags), .nvm_write_out(nvm_write_out),
        .nvm_data_out(nvm_data), .client_address_out(caddr));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic hrst(input logic s, input logic [1:0] p);
        reset_in <= 1'b1;
        sel <= s;
        pin <= p;
        repeat (3) @(posedge clk_in);
        chk({1'b0, caddr}, 8'h00);
        reset_in <= 1'b0;
        repeat (12) @(posedge clk_in);
    endtask
    task automatic wb(input logic [7:0] d, input logic ack);
        logic a;
        host.wbyte(d, a);
        chk({7'h0, a}, {7'h0, ack});
    endtask
    task automatic ptr(input logic [15:0] a);
        host.start();
        wb({dev, 1'b0}, 1'b1);
        wb(a[15:8], 1'b1);
        wb(a[7:0], 1'b1);
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d, input int n);
        ptr(a);
        for (int i = 0; i < n; i++) wb(d + 8'(i), 1'b1);
        host.stop();
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] d, input int n);
        logic [7:0] v;
        ptr(a);
        host.start();
        wb({dev, 1'b1}, 1'b1);
        for (int i = 0; i < n; i++) begin
            host.rbyte(v, i == n - 1);
            chk(v, d + 8'(i));
        end
        host.stop();
    endtask
    initial begin
        for (int r = 0; r < 4; r++) begin
            hrst(1'b0, rows[r][8:7]);
            chk({1'b0, caddr}, {1'b0, rows[r][6:0]});
        end
        wr(16'h0000, 8'h00, 1);
        wr(16'h0005, 8'hA5, 1);
        rd(16'h0005, 8'hA5, 1);
        wr(16'h0001, 8'h10, 3);
        rd(16'h0001, 8'h10, 3);
        dev = 7'h65;
        host.start();
        wb({dev, 1'b0}, 1'b0);
        host.stop();
        dev = 7'h66;
        wr(REG_SOFT_RESET, 8'h40, 1);
        chk({7'h0, ctrl.global_soft_reset}, 8'h01);
        wr(REG_SOFT_RESET, 8'h47, 1);
        wr(REG_SOFT_RESET, 8'h78, 1);
        chk({2'h0, ctrl.digital_loop_soft_reset, ctrl.analog_loop_soft_reset}, 8'h00);
        rd(REG_SOFT_RESET, 8'h40, 1);
        chk({2'h0, seen}, 8'h3F);
        wr(REG_SOFT_RESET, 8'h00, 1);
        chk({7'h0, ctrl.global_soft_reset}, 8'h00);
        lost <= 3'h2;
        repeat (20) @(posedge clk_in);
        rd(REG_LOCK_STATUS, 8'h02, 1);
        lost <= 3'h0;
        repeat (10) @(posedge clk_in);
        rd(REG_LOCK_STATUS, 8'h00, 1);
        chk({5'h0, flags}, 8'h02);
        rd(REG_INT_FLAGS, 8'h02, 1);
        wr(REG_INT_FLAGS, 8'h02, 1);
        rd(REG_INT_FLAGS, 8'h00, 1);
        wr(REG_SYNC_EN, 8'h01, 1);
        wr(REG_SYNC_TRIG, 8'h40, 1);
        chk({6'h0, ctrl.sync_enable, ctrl.software_sync_trigger}, 8'h03);
        wr(REG_SYNC_TRIG, 8'h00, 1);
        chk({7'h0, ctrl.software_sync_trigger}, 8'h00);
        wr(REG_NVM_STAGE, 8'h15, 1);
        wr(REG_NVM_CTRL, 8'h01, 1);
        chk({2'h0, stored}, 8'h35);
        hrst(1'b1, 2'h2);
        host.start();
        wb({dev, 1'b0}, 1'b0);
        host.stop();
        end_of_test();
    end
endmodule // tb_top
`default_nettype wire
